// ### rotc_top.sv
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module rotc_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic video_locked,
    input wire logic [23:0] rx_timecode_time,
    input wire logic rx_timecode_valid,
    input wire logic [31:0] rx_timeref_time,
    input wire logic [7:0] rx_timeref_tz,
    input wire logic rx_timeref_valid,
    input wire logic [23:0] now_time,
    input wire logic [31:0] now_date,
    output rotc_pkg::rotc_input_cfg_t input_cfg,
    output rotc_pkg::rotc_burst_cfg_t [rotc_pkg::NUM_OUT-1:0] burst_cfg,
    output logic [rotc_pkg::NUM_OUT-1:0] burst_drive_en,
    output rotc_pkg::rotc_timeref_cfg_t timeref_cfg,
    output logic [31:0] embedded_time,
    output logic embedded_time_valid,
    output logic [7:0] timezone
);

    rotc_pkg::rotc_input_cfg_t in_cfg_r;
    rotc_pkg::rotc_burst_cfg_t [rotc_pkg::NUM_OUT-1:0] burst_r;
    logic [rotc_pkg::NUM_OUT-1:0] drive_en_r;
    logic [1:0] out_sel_r;
    logic [31:0] in_ofst_r;
    logic [31:0] staged_r;
    logic [31:0] applied_r;
    logic [23:0] trig_time_r;
    logic [31:0] trig_date_r;
    logic delayed_trig_r;
    logic level_trig_r;
    logic trig_fired_r;
    logic [15:0] clk_dly_r;
    logic [9:0] line_dly_r;
    logic [4:0] frame_dly_r;
    logic [31:0] emb_time_r;
    logic emb_valid_r;
    logic [7:0] tz_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic date_hit;
    logic trig_now;
    rotc_pkg::rotc_burst_cfg_t cur;

    // Write strobes
    logic wr_in_cfg;
    logic wr_out_ctrl;
    assign wr_in_cfg = reg_wr && (reg_addr == rotc_pkg::REG_INPUT_CFG);
    assign wr_out_ctrl = reg_wr && (reg_addr == rotc_pkg::REG_OUT_CTRL);

    // Input-side settings
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            in_cfg_r.embedded_time_source_sel <= rotc_pkg::EMB_NONE;
            in_cfg_r.input_timeref_offset_en <= 1'b0;
            in_cfg_r.input_timeref_tz_read <= 1'b0;
            in_cfg_r.genlock_source_sel <= rotc_pkg::GL_COMPANION;
            in_cfg_r.input_timecode_line <= rotc_pkg::LINE_DEF;
        end else begin
            if (wr_in_cfg) begin
                // Reserved source code is ignored
                if (reg_wdata[rotc_pkg::IN_EMB_LSB +: 2] != 2'h3) begin
                    in_cfg_r.embedded_time_source_sel <=
                        rotc_pkg::rotc_emb_t'(reg_wdata[rotc_pkg::IN_EMB_LSB +: 2]);
                end
                in_cfg_r.input_timeref_offset_en <= reg_wdata[rotc_pkg::IN_OFST_EN_BIT];
                in_cfg_r.input_timeref_tz_read <= reg_wdata[rotc_pkg::IN_TZ_BIT];
                in_cfg_r.genlock_source_sel <=
                    rotc_pkg::rotc_genlock_t'(reg_wdata[rotc_pkg::IN_GL_BIT]);
            end
            if (reg_wr && reg_addr == rotc_pkg::REG_INPUT_LINE) begin
                in_cfg_r.input_timecode_line <= 5'(rotc_pkg::rotc_clip(reg_wdata,
                    rotc_pkg::LINE_MIN, rotc_pkg::LINE_MAX));
            end
        end
    end

    // Input offset value and output selector
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            in_ofst_r <= 32'h00000000;
            out_sel_r <= 2'h0;
        end else begin
            if (reg_wr && reg_addr == rotc_pkg::REG_INPUT_OFST) begin
                in_ofst_r <= reg_wdata;
            end
            if (reg_wr && reg_addr == rotc_pkg::REG_OUT_SEL) begin
                out_sel_r <= reg_wdata[1:0];
            end
        end
    end

    // Per-output settings, addressed through the selector
    generate
        for (genvar i = 0; i < rotc_pkg::NUM_OUT; i++) begin : g_out
            logic hit;
            assign hit = reg_wr && (out_sel_r == 2'(i));
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    burst_r[i].burst_output_en <= 1'b0;
                    burst_r[i].burst_output_standard <= rotc_pkg::STD_NTSC;
                    burst_r[i].burst_pedestal_en <= 1'b0;
                    burst_r[i].ten_field_seq_en <= 1'b0;
                    burst_r[i].timeref_insert_en <= 1'b0;
                    burst_r[i].timeref_track_mode <= rotc_pkg::TRACK_NONE;
                    burst_r[i].output_timecode_insert_en <= 1'b0;
                    burst_r[i].output_timecode_second_line <= rotc_pkg::LINE_DEF;
                    burst_r[i].burst_fine_phase <= 16'h0000;
                    burst_r[i].burst_horiz_phase <= 16'h0000;
                    burst_r[i].burst_vert_phase <= 10'h000;
                end else if (hit) begin
                    if (wr_out_ctrl) begin
                        burst_r[i].burst_output_en <= reg_wdata[rotc_pkg::CT_EN_BIT];
                        // Codes past the last standard leave the standard unchanged
                        if (reg_wdata[rotc_pkg::CT_STD_LSB +: 4] <= 4'(rotc_pkg::STD_720P_50)) begin
                            burst_r[i].burst_output_standard <=
                                rotc_pkg::rotc_std_t'(reg_wdata[rotc_pkg::CT_STD_LSB +: 4]);
                        end
                        burst_r[i].burst_pedestal_en <= reg_wdata[rotc_pkg::CT_PED_BIT];
                        burst_r[i].ten_field_seq_en <= reg_wdata[rotc_pkg::CT_TEN_BIT];
                        burst_r[i].timeref_insert_en <= reg_wdata[rotc_pkg::CT_TRI_BIT];
                        if (reg_wdata[rotc_pkg::CT_TRK_LSB +: 2] != 2'h3) begin
                            burst_r[i].timeref_track_mode <=
                                rotc_pkg::rotc_track_t'(reg_wdata[rotc_pkg::CT_TRK_LSB +: 2]);
                        end
                        burst_r[i].output_timecode_insert_en <= reg_wdata[rotc_pkg::CT_VITC_BIT];
                    end
                    if (reg_addr == rotc_pkg::REG_OUT_LINE2) begin
                        burst_r[i].output_timecode_second_line <= 5'(rotc_pkg::rotc_clip(reg_wdata,
                            rotc_pkg::LINE_MIN, rotc_pkg::LINE_MAX));
                    end
                    if (reg_addr == rotc_pkg::REG_OUT_FINE) begin
                        burst_r[i].burst_fine_phase <=
                            16'(rotc_pkg::rotc_wrap(reg_wdata, rotc_pkg::FINE_LEN));
                    end
                    if (reg_addr == rotc_pkg::REG_OUT_HORIZ) begin
                        burst_r[i].burst_horiz_phase <=
                            16'(rotc_pkg::rotc_wrap(reg_wdata, rotc_pkg::HORIZ_LEN));
                    end
                    if (reg_addr == rotc_pkg::REG_OUT_VERT) begin
                        burst_r[i].burst_vert_phase <=
                            10'(rotc_pkg::rotc_wrap(reg_wdata, rotc_pkg::VERT_LEN));
                    end
                end
            end

            // Output stage follows its enable one cycle after the setting
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    drive_en_r[i] <= 1'b0;
                end else begin
                    drive_en_r[i] <= burst_r[i].burst_output_en;
                end
            end
        end
    endgenerate

    // Time-reference delays, clipped on write
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            clk_dly_r <= 16'h0000;
            line_dly_r <= 10'h000;
            frame_dly_r <= 5'h00;
        end else if (reg_wr) begin
            if (reg_addr == rotc_pkg::REG_TR_CLK_DLY) begin
                clk_dly_r <= 16'(rotc_pkg::rotc_clip(reg_wdata, 32'h00000000,
                    rotc_pkg::CLK_DLY_MAX));
            end
            if (reg_addr == rotc_pkg::REG_TR_LINE_DLY) begin
                line_dly_r <= 10'(rotc_pkg::rotc_clip(reg_wdata, 32'h00000000,
                    rotc_pkg::LINE_DLY_MAX));
            end
            if (reg_addr == rotc_pkg::REG_TR_FRAME_DLY) begin
                frame_dly_r <= 5'(rotc_pkg::rotc_clip(reg_wdata, 32'h00000000,
                    rotc_pkg::FRAME_DLY_MAX));
            end
        end
    end

    // Staged offset and trigger settings
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            staged_r <= 32'h00000000;
            trig_time_r <= rotc_pkg::TRIG_TIME_DEF;
            trig_date_r <= rotc_pkg::TRIG_DATE_DEF;
            delayed_trig_r <= 1'b0;
            level_trig_r <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == rotc_pkg::REG_TR_STAGED) begin
                staged_r <= reg_wdata;
            end
            if (reg_addr == rotc_pkg::REG_TR_TIME) begin
                trig_time_r <= reg_wdata[23:0];
            end
            if (reg_addr == rotc_pkg::REG_TR_DATE) begin
                trig_date_r <= reg_wdata;
            end
            if (reg_addr == rotc_pkg::REG_TR_TRIG) begin
                delayed_trig_r <= reg_wdata[rotc_pkg::TG_DELAYED_BIT];
                level_trig_r <= reg_wdata[rotc_pkg::TG_LEVEL_BIT];
            end
        end
    end

    // Trigger condition
    assign date_hit = (now_time == trig_time_r) && (now_date == trig_date_r);
    assign trig_now = level_trig_r || (delayed_trig_r && date_hit);

    // Applied offset changes only on a trigger
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            applied_r <= 32'h00000000;
            trig_fired_r <= 1'b0;
        end else begin
            if (trig_now) begin
                applied_r <= staged_r;
            end
            // Sticky fired flag; set wins over a clearing write
            if (delayed_trig_r && date_hit) begin
                trig_fired_r <= 1'b1;
            end else if (reg_wr && reg_addr == rotc_pkg::REG_STATUS) begin
                trig_fired_r <= 1'b0;
            end
        end
    end

    // Embedded time taken from the chosen source while locked
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            emb_time_r <= 32'h00000000;
            emb_valid_r <= 1'b0;
        end else begin
            emb_valid_r <= 1'b0;
            if (video_locked) begin
                unique case (in_cfg_r.embedded_time_source_sel)
                    rotc_pkg::EMB_VITC: begin
                        if (rx_timecode_valid) begin
                            emb_time_r <= {8'h00, rx_timecode_time};
                            emb_valid_r <= 1'b1;
                        end
                    end
                    rotc_pkg::EMB_TIMEREF: begin
                        if (rx_timeref_valid) begin
                            emb_time_r <= in_cfg_r.input_timeref_offset_en ?
                                rx_timeref_time + in_ofst_r : rx_timeref_time;
                            emb_valid_r <= 1'b1;
                        end
                    end
                    default: begin
                        emb_valid_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Timezone from the received payload
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tz_r <= 8'h00;
        end else if (in_cfg_r.input_timeref_tz_read && rx_timeref_valid) begin
            tz_r <= rx_timeref_tz;
        end
    end

    // Read mux over the selected output
    assign cur = burst_r[out_sel_r];
    always_comb begin
        rdata_nxt = 32'h00000000;
        if (reg_rd) begin
            unique case (reg_addr)
                rotc_pkg::REG_INPUT_CFG: begin
                    rdata_nxt = {27'h0000000, in_cfg_r.genlock_source_sel, in_cfg_r.input_timeref_tz_read,
                                 in_cfg_r.input_timeref_offset_en, in_cfg_r.embedded_time_source_sel};
                end
                rotc_pkg::REG_INPUT_LINE: rdata_nxt = {27'h0000000, in_cfg_r.input_timecode_line};
                rotc_pkg::REG_INPUT_OFST: rdata_nxt = in_ofst_r;
                rotc_pkg::REG_OUT_SEL: rdata_nxt = {30'h00000000, out_sel_r};
                rotc_pkg::REG_OUT_CTRL: begin
                    rdata_nxt = {21'h000000, cur.output_timecode_insert_en, cur.timeref_track_mode,
                                 cur.timeref_insert_en, cur.ten_field_seq_en, cur.burst_pedestal_en,
                                 cur.burst_output_standard, cur.burst_output_en};
                end
                rotc_pkg::REG_OUT_LINE2: rdata_nxt = {27'h0000000, cur.output_timecode_second_line};
                rotc_pkg::REG_OUT_FINE: rdata_nxt = {16'h0000, cur.burst_fine_phase};
                rotc_pkg::REG_OUT_HORIZ: rdata_nxt = {16'h0000, cur.burst_horiz_phase};
                rotc_pkg::REG_OUT_VERT: rdata_nxt = {22'h000000, cur.burst_vert_phase};
                rotc_pkg::REG_TR_STAGED: rdata_nxt = staged_r;
                rotc_pkg::REG_TR_APPLIED: rdata_nxt = applied_r;
                rotc_pkg::REG_TR_TIME: rdata_nxt = {8'h00, trig_time_r};
                rotc_pkg::REG_TR_DATE: rdata_nxt = trig_date_r;
                rotc_pkg::REG_TR_TRIG: rdata_nxt = {30'h00000000, level_trig_r, delayed_trig_r};
                rotc_pkg::REG_TR_CLK_DLY: rdata_nxt = {16'h0000, clk_dly_r};
                rotc_pkg::REG_TR_LINE_DLY: rdata_nxt = {22'h000000, line_dly_r};
                rotc_pkg::REG_TR_FRAME_DLY: rdata_nxt = {27'h0000000, frame_dly_r};
                rotc_pkg::REG_STATUS: rdata_nxt = {27'h0000000, drive_en_r, trig_fired_r};
                default: rdata_nxt = 32'h00000000;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_r <= 32'h00000000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata = rdata_r;
    assign input_cfg = in_cfg_r;
    assign burst_cfg = burst_r;
    assign burst_drive_en = drive_en_r;
    assign timeref_cfg = {applied_r, clk_dly_r, line_dly_r, frame_dly_r};
    assign embedded_time = emb_time_r;
    assign embedded_time_valid = emb_valid_r;
    assign timezone = tz_r;

endmodule : rotc_top

// ### rotc_pkg.sv
package rotc_pkg;

    // Register byte addresses
    localparam logic [7:0] REG_INPUT_CFG = 8'h00;
    localparam logic [7:0] REG_INPUT_LINE = 8'h04;
    localparam logic [7:0] REG_INPUT_OFST = 8'h08;
    localparam logic [7:0] REG_OUT_SEL = 8'h0c;
    localparam logic [7:0] REG_OUT_CTRL = 8'h10;
    localparam logic [7:0] REG_OUT_LINE2 = 8'h14;
    localparam logic [7:0] REG_OUT_FINE = 8'h18;
    localparam logic [7:0] REG_OUT_HORIZ = 8'h1c;
    localparam logic [7:0] REG_OUT_VERT = 8'h20;
    localparam logic [7:0] REG_TR_STAGED = 8'h24;
    localparam logic [7:0] REG_TR_APPLIED = 8'h28;
    localparam logic [7:0] REG_TR_TIME = 8'h2c;
    localparam logic [7:0] REG_TR_DATE = 8'h30;
    localparam logic [7:0] REG_TR_TRIG = 8'h34;
    localparam logic [7:0] REG_TR_CLK_DLY = 8'h38;
    localparam logic [7:0] REG_TR_LINE_DLY = 8'h3c;
    localparam logic [7:0] REG_TR_FRAME_DLY = 8'h40;
    localparam logic [7:0] REG_STATUS = 8'h44;

    // Field positions
    localparam int unsigned IN_EMB_LSB = 0;
    localparam int unsigned IN_OFST_EN_BIT = 2;
    localparam int unsigned IN_TZ_BIT = 3;
    localparam int unsigned IN_GL_BIT = 4;
    localparam int unsigned CT_EN_BIT = 0;
    localparam int unsigned CT_STD_LSB = 1;
    localparam int unsigned CT_PED_BIT = 5;
    localparam int unsigned CT_TEN_BIT = 6;
    localparam int unsigned CT_TRI_BIT = 7;
    localparam int unsigned CT_TRK_LSB = 8;
    localparam int unsigned CT_VITC_BIT = 10;
    localparam int unsigned TG_DELAYED_BIT = 0;
    localparam int unsigned TG_LEVEL_BIT = 1;

    // Limits and reset values
    localparam logic [31:0] LINE_MIN = 32'h0000000a;
    localparam logic [31:0] LINE_MAX = 32'h00000014;
    localparam logic [4:0] LINE_DEF = 5'h0e;
    localparam logic [31:0] FINE_LEN = 32'h0000901d;
    localparam logic [31:0] HORIZ_LEN = 32'h0000f820;
    localparam logic [31:0] VERT_LEN = 32'h0000020d;
    localparam logic [31:0] CLK_DLY_MAX = 32'h0000f81f;
    localparam logic [31:0] LINE_DLY_MAX = 32'h0000020c;
    localparam logic [31:0] FRAME_DLY_MAX = 32'h0000001d;
    localparam logic [31:0] TRIG_DATE_DEF = 32'h20580101;
    localparam logic [23:0] TRIG_TIME_DEF = 24'h000000;
    localparam int unsigned NUM_OUT = 4;

    typedef enum logic [1:0] {EMB_NONE, EMB_VITC, EMB_TIMEREF} rotc_emb_t;
    typedef enum logic {GL_COMPANION, GL_EXTERNAL} rotc_genlock_t;
    typedef enum logic [1:0] {TRACK_NONE, TRACK_OFFSET, TRACK_TIME} rotc_track_t;
    typedef enum logic [3:0] {
        STD_NTSC, STD_PAL_B, STD_PAL_M, STD_1080I_60, STD_1080I_5994, STD_1080P_594,
        STD_1080PSF_24, STD_1080P_30, STD_1080P_2997, STD_1080P_25, STD_1080P_24,
        STD_1080P_2398, STD_720P_60, STD_720P_50
    } rotc_std_t;

    typedef struct packed {
        rotc_emb_t embedded_time_source_sel;
        logic input_timeref_offset_en;
        logic input_timeref_tz_read;
        rotc_genlock_t genlock_source_sel;
        logic [4:0] input_timecode_line;
    } rotc_input_cfg_t;

    typedef struct packed {
        logic burst_output_en;
        rotc_std_t burst_output_standard;
        logic burst_pedestal_en;
        logic ten_field_seq_en;
        logic timeref_insert_en;
        rotc_track_t timeref_track_mode;
        logic output_timecode_insert_en;
        logic [4:0] output_timecode_second_line;
        logic [15:0] burst_fine_phase;
        logic [15:0] burst_horiz_phase;
        logic [9:0] burst_vert_phase;
    } rotc_burst_cfg_t;

    typedef struct packed {
        logic [31:0] timeref_applied_offset;
        logic [15:0] timeref_clock_delay;
        logic [9:0] timeref_line_delay;
        logic [4:0] timeref_frame_delay;
    } rotc_timeref_cfg_t;

    // Saturate at the nearest limit
    function automatic logic [31:0] rotc_clip(input logic [31:0] v, input logic [31:0] lo,
                                              input logic [31:0] hi);
        rotc_clip = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : rotc_clip

    // Reduce modulo the range length
    function automatic logic [31:0] rotc_wrap(input logic [31:0] v, input logic [31:0] len);
        rotc_wrap = v % len;
    endfunction : rotc_wrap

endpackage : rotc_pkg

// ### rotc_chk.sv
`timescale 1ns/1ps
module rotc_chk (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input rotc_pkg::rotc_input_cfg_t input_cfg,
    input rotc_pkg::rotc_burst_cfg_t [rotc_pkg::NUM_OUT-1:0] burst_cfg,
    input wire logic [rotc_pkg::NUM_OUT-1:0] burst_drive_en,
    input rotc_pkg::rotc_timeref_cfg_t timeref_cfg
);
    logic [1:0] sel_r;
    logic [1:0] trig_r;
    logic [3:0] en_v;
    logic [7:0] wa;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Write address, 0xff when idle
    assign wa = reg_wr ? reg_addr : 8'hff;
    // Enables of all outputs
    always_comb for (int i = 0; i < 4; i++) en_v[i] = burst_cfg[i].burst_output_en;
    // Selected output and trigger mode
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sel_r <= 2'h0;
            trig_r <= 2'h0;
        end else if (wa == rotc_pkg::REG_OUT_SEL) begin
            sel_r <= reg_wdata[1:0];
        end else if (wa == rotc_pkg::REG_TR_TRIG) begin
            trig_r <= reg_wdata[1:0];
        end
    end
    AST_DRV: assert property (burst_drive_en == ($past(rst) ? 4'h0 : $past(en_v)))
        else $error("drive enable wrong");
    AST_LINE_HI: assert property (wa == rotc_pkg::REG_INPUT_LINE && reg_wdata > 32'h14
        |=> input_cfg.input_timecode_line == 5'h14) else $error("line not clipped high");
    AST_LINE_LO: assert property (wa == rotc_pkg::REG_INPUT_LINE && reg_wdata < 32'h0a
        |=> input_cfg.input_timecode_line == 5'h0a) else $error("line not clipped low");
    AST_CLK_DLY: assert property (wa == rotc_pkg::REG_TR_CLK_DLY && reg_wdata > 32'hf81f
        |=> timeref_cfg.timeref_clock_delay == 16'hf81f) else $error("clock delay not clipped");
    AST_FRAME: assert property (wa == rotc_pkg::REG_TR_FRAME_DLY && reg_wdata > 32'h1d
        |=> timeref_cfg.timeref_frame_delay == 5'h1d) else $error("frame delay not clipped");
    AST_VERT: assert property (wa == rotc_pkg::REG_OUT_VERT
        |=> burst_cfg[sel_r].burst_vert_phase == 10'($past(reg_wdata) % 32'h20d)) else $error("vert not wrapped");
    AST_HORIZ: assert property (wa == rotc_pkg::REG_OUT_HORIZ
        |=> burst_cfg[sel_r].burst_horiz_phase == 16'($past(reg_wdata) % 32'hf820)) else $error("horiz not wrapped");
    AST_HOLD: assert property (trig_r == 2'h0
        |=> $stable(timeref_cfg.timeref_applied_offset)) else $error("offset moved without trigger");
endmodule : rotc_chk
bind rotc_top rotc_chk u_chk (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .input_cfg, .burst_cfg,
    .burst_drive_en, .timeref_cfg);

// ### rotc_sink.sv
`timescale 1ns/1ps
module rotc_sink (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] burst_drive_en,
    output logic [3:0] seen_r
);
    // Remembers every output that ever carried signal
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            seen_r <= 4'h0;
        end else begin
            seen_r <= seen_r | burst_drive_en;
        end
    end
endmodule : rotc_sink

// ### tb_top.sv
`timescale 1ns/1ps
`define CHK_EQ(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; $display("CHECK FAILED %0t mismatch", $time); end end
module tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, video_locked = 1'b0, rx_timeref_valid = 1'b0;
    logic [31:0] rx_timeref_time = 32'h0, now_date = 32'h0, reg_rdata, embedded_time;
    logic [7:0] rx_timeref_tz = 8'h00, timezone;
    logic [23:0] now_time = 24'h0;
    logic [23:0] rx_timecode_time = 24'h0;
    logic rx_timecode_valid = 1'b0;
    rotc_pkg::rotc_input_cfg_t input_cfg;
    rotc_pkg::rotc_burst_cfg_t [3:0] burst_cfg;
    rotc_pkg::rotc_timeref_cfg_t timeref_cfg;
    logic [3:0] burst_drive_en, seen_r;
    logic embedded_time_valid;
    int checked = 0, n_mismatch = 0, cyc = 0;
    logic [31:0] rows [10][3] = '{
        '{32'h04, 32'h05, 32'h0a},
        '{32'h04, 32'h63, 32'h14},
        '{32'h04, 32'h0f, 32'h0f},
        '{32'h14, 32'h00, 32'h0a},
        '{32'h38, 32'h11170, 32'hf81f},
        '{32'h3c, 32'h258, 32'h20c},
        '{32'h40, 32'h1e, 32'h1d},
        '{32'h18, 32'h901d, 32'h0},
        '{32'h1c, 32'hf821, 32'h1},
        '{32'h20, 32'h419, 32'h20c}};
    rotc_top u_dut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .video_locked,
        .rx_timecode_time, .rx_timecode_valid, .rx_timeref_time, .rx_timeref_tz, .rx_timeref_valid,
        .now_time, .now_date, .input_cfg, .burst_cfg, .burst_drive_en, .timeref_cfg, .embedded_time,
        .embedded_time_valid, .timezone);
    rotc_sink u_sink (.ref_clk, .rst, .burst_drive_en, .seen_r);
    // Clock and hang guard
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    // Read, then compare in the answer cycle
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK_EQ(reg_rdata, e)
    endtask : rc
    // One-cycle receive pulse on both embedded sources
    task automatic rx_pulse();
        @(posedge ref_clk);
        rx_timecode_valid <= 1'b1;
        rx_timeref_valid <= 1'b1;
        @(posedge ref_clk);
        rx_timecode_valid <= 1'b0;
        rx_timeref_valid <= 1'b0;
        #1;
    endtask : rx_pulse
    // Main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i][0][7:0], rows[i][1]);
            rc(rows[i][0][7:0], rows[i][2]);
        end
        rc(8'h80, 32'h0);
        wr(8'h0c, 32'h2);
        for (int i = 0; i < 15; i++) begin
            wr(8'h10, (32'(i) << 1) | 32'h1);
            `CHK_EQ(burst_cfg[2].burst_output_standard, rotc_pkg::rotc_std_t'(i > 13 ? 13 : i))
        end
        `CHK_EQ(burst_drive_en, 4'h4)
        `CHK_EQ(burst_cfg[0].burst_output_en, 1'b0)
        `CHK_EQ(seen_r, 4'h4)
        wr(8'h10, 32'h6e1);
        `CHK_EQ(burst_cfg[2].burst_pedestal_en, 1'b1)
        `CHK_EQ(burst_cfg[2].ten_field_seq_en, 1'b1)
        `CHK_EQ(burst_cfg[2].timeref_insert_en, 1'b1)
        `CHK_EQ(burst_cfg[2].output_timecode_insert_en, 1'b1)
        `CHK_EQ(burst_cfg[2].timeref_track_mode, rotc_pkg::TRACK_TIME)
        wr(8'h24, 32'h1234);
        rc(8'h28, 32'h0);
        wr(8'h34, 32'h2);
        rc(8'h28, 32'h1234);
        wr(8'h34, 32'h0);
        wr(8'h24, 32'h5678);
        wr(8'h28, 32'h9);
        rc(8'h28, 32'h1234);
        wr(8'h2c, 32'h123456);
        wr(8'h30, 32'h20300101);
        wr(8'h34, 32'h1);
        rc(8'h28, 32'h1234);
        @(posedge ref_clk);
        now_time <= 24'h123456;
        now_date <= 32'h20300101;
        rc(8'h28, 32'h5678);
        rc(8'h44, 32'h9);
        wr(8'h44, 32'h0);
        rc(8'h44, 32'h9);
        wr(8'h08, 32'h5);
        wr(8'h00, 32'h1e);
        `CHK_EQ(input_cfg.genlock_source_sel, rotc_pkg::GL_EXTERNAL)
        @(posedge ref_clk);
        video_locked <= 1'b1;
        rx_timeref_time <= 32'h64;
        rx_timeref_tz <= 8'h07;
        rx_timecode_time <= 24'h123456;
        rx_pulse();
        `CHK_EQ(embedded_time, 32'h69)
        `CHK_EQ(embedded_time_valid, 1'b1)
        `CHK_EQ(timezone, 8'h07)
        // Timecode source; payload timezone ignored while its read is off
        wr(8'h00, 32'h1);
        @(posedge ref_clk);
        rx_timeref_tz <= 8'h09;
        rx_pulse();
        `CHK_EQ(embedded_time, 32'h00123456)
        `CHK_EQ(embedded_time_valid, 1'b1)
        `CHK_EQ(timezone, 8'h07)
        wr(8'h00, 32'h2);
        rx_pulse();
        `CHK_EQ(embedded_time, 32'h64)
        wr(8'h00, 32'h0);
        rx_pulse();
        `CHK_EQ(embedded_time_valid, 1'b0)
        @(posedge ref_clk);
        rst <= 1'b1;
        @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        `CHK_EQ(input_cfg.input_timecode_line, 5'h0e)
        `CHK_EQ(input_cfg.embedded_time_source_sel, rotc_pkg::EMB_NONE)
        `CHK_EQ(burst_cfg[2].burst_output_en, 1'b0)
        rc(8'h30, 32'h20580101);
        print_verdict();
    end
endmodule : tb_top
